// file: rtl/camera_video_link_output.sv
`default_nettype none
// Operation
// - Pixel clock runs at 40 MHz without binning.
// - Horizontal or full binning halves the pixel clock to 20 MHz.
// - Data and qualifiers change only on the pixel clock falling edge.
// - Frame qualifier stays high while a valid frame is sent.
// - Line qualifier stays high while a valid line is sent.
// - Pixel words count only where both qualifiers are high.
// - 10-bit mode: odd bits 0-7 on A0-A7, bits 8-9 on B0-B1.
// - 10-bit mode: even 0-7 on C, 8-9 on B4-B5, B2,B3,B6,B7 unused.
// - 8-bit mode: odd pixel bits 0-7 on port A.
// - 8-bit mode: even pixel bits 0-7 on port B, port C unused.
// - Qualifiers and pixel clock keep fixed positions in every mode.
// - Exactly two formats, dual 10-bit and dual 8-bit, two pixels per clock.
// - Frame trigger is the only control input taken.
// - Trigger edges start frames; a steady trigger level starts nothing.
// - One frame is acquired per trigger period.
// - Exposure is level-controlled or programmable, selected by configuration.
// - 8-bit mode drops the two low bits of each 10-bit sample.
// - Line qualifier is low on every cycle with no valid data; frame qualifier stays high in line gaps.
// - Exposure-active output is high exactly during each exposure.
module camera_video_link_output #(
  parameter int PIX_W = pixel_link_pkg::PIX_W,
  parameter int PORT_W = pixel_link_pkg::PORT_W,
  parameter int EXPO_W = pixel_link_pkg::EXPO_W
) (
  input wire logic sys_clk_i,                     // 200 MHz system clock.
  input wire logic rstn_i,                        // Asynchronous reset, active low.
  input wire logic frame_trigger_input_i,         // Frame trigger pin, asynchronous.
  input wire logic cfg_8bit_i,                    // 1 selects dual 8-bit, 0 dual 10-bit.
  input wire logic cfg_bin_i,                     // Horizontal or full binning enabled.
  input wire logic cfg_prog_expo_i,               // 1 selects programmable exposure.
  input wire logic [EXPO_W-1:0] cfg_expo_len_i,   // Programmable exposure, system cycles.
  input wire logic [PIX_W-1:0] pix_odd_i,         // Odd pixel sample.
  input wire logic [PIX_W-1:0] pix_even_i,        // Even pixel sample.
  input wire logic pix_fval_i,                    // Source frame valid.
  input wire logic pix_lval_i,                    // Source line valid.
  output logic pix_take_o,                        // Pulse: pixel pair was taken.
  output logic [PORT_W-1:0] port_a_o,             // Serializer port A.
  output logic [PORT_W-1:0] port_b_o,             // Serializer port B.
  output logic [PORT_W-1:0] port_c_o,             // Serializer port C.
  output logic lval_o,                            // Line qualifier to serializer.
  output logic fval_o,                            // Frame qualifier to serializer.
  output logic pclk_o,                            // Pixel clock to serializer.
  output logic exposure_active_output_o,          // High while an exposure runs.
  output logic frame_start_o                      // Pulse: exposure ended, read out a frame.
);
  typedef enum logic {ST_IDLE, ST_EXPOSE} expo_state_e;

  logic mode8;
  logic bin_q;
  logic fall;
  logic [pixel_link_pkg::DIV_W-1:0] div_cur;
  logic [pixel_link_pkg::DIV_W-1:0] next_div;
  logic trig_s1;
  logic trig_s2;
  logic trig_s3;
  logic trig_rise;
  logic trig_fall;
  logic next_valid;
  logic [PORT_W-1:0] next_a;
  logic [PORT_W-1:0] next_b;
  logic [PORT_W-1:0] next_c;
  expo_state_e state;
  pixel_link_pkg::expo_mode_e expo_mode;
  logic [EXPO_W-1:0] expo_cnt;
  logic [EXPO_W-1:0] expo_len;
  logic expo_done;

  assign next_div = bin_q ? pixel_link_pkg::DIV_BIN : pixel_link_pkg::DIV_FULL;

  pclk_divider #(
    .DIV_W(pixel_link_pkg::DIV_W)
  ) u_pclk_divider (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .div_i(next_div),
    .pclk_o(pclk_o),
    .fall_o(fall),
    .div_cur_o(div_cur)
  );

  // Format and binning are latched only in a frame gap, so a frame never mixes layouts.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode8 <= 1'b0;
      bin_q <= 1'b0;
    end else if (!fval_o && !pix_fval_i) begin
      mode8 <= cfg_8bit_i;
      bin_q <= cfg_bin_i;
    end
  end

  // Dual 8-bit keeps the upper bits of each sample; dual 10-bit splits the top two onto B.
  always_comb begin
    next_valid = pix_fval_i && pix_lval_i;
    next_a = '0;
    next_b = '0;
    next_c = '0;
    if (next_valid) begin
      if (mode8) begin
        next_a = pix_odd_i[PIX_W-1:pixel_link_pkg::DROP_LSBS];
        next_b = pix_even_i[PIX_W-1:pixel_link_pkg::DROP_LSBS];
      end else begin
        next_a = pix_odd_i[PORT_W-1:0];
        next_b[pixel_link_pkg::B_ODD_MSB_POS +: 2] = pix_odd_i[PIX_W-1:PORT_W];
        next_b[pixel_link_pkg::B_EVEN_MSB_POS +: 2] = pix_even_i[PIX_W-1:PORT_W];
        next_c = pix_even_i[PORT_W-1:0];
      end
    end
  end

  // All serializer words load on the edge that drops the pixel clock.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      port_a_o <= '0;
      port_b_o <= '0;
      port_c_o <= '0;
    end else if (fall) begin
      port_a_o <= next_a;
      port_b_o <= next_b;
      port_c_o <= next_c;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fval_o <= 1'b0;
      lval_o <= 1'b0;
    end else if (fall) begin
      fval_o <= pix_fval_i;
      lval_o <= next_valid;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pix_take_o <= 1'b0;
    end else begin
      pix_take_o <= fall;
    end
  end

  // The trigger pin is the only control input; the first stage feeds only the second.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_s3 <= 1'b0;
    end else begin
      trig_s1 <= frame_trigger_input_i;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
    end
  end

  assign trig_rise = trig_s2 && !trig_s3;
  assign trig_fall = !trig_s2 && trig_s3;
  assign expo_done = (expo_mode == pixel_link_pkg::EXPO_LEVEL) ? trig_fall
                   : (expo_cnt >= expo_len);

  // A rising edge during an exposure is ignored; a short high phase below the
  // grabber's minimum still yields a frame; in level mode its exposure is then very short.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (trig_rise) begin
            state <= ST_EXPOSE;
          end
        end
        ST_EXPOSE: begin
          if (expo_done) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      expo_mode <= pixel_link_pkg::EXPO_LEVEL;
      expo_len <= '0;
    end else if (state == ST_IDLE && trig_rise) begin
      expo_mode <= cfg_prog_expo_i ? pixel_link_pkg::EXPO_PROG : pixel_link_pkg::EXPO_LEVEL;
      expo_len <= (cfg_expo_len_i == '0) ? EXPO_W'(1) : cfg_expo_len_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      expo_cnt <= '0;
    end else if (state == ST_IDLE) begin
      expo_cnt <= EXPO_W'(1);
    end else if (expo_cnt != '1) begin
      expo_cnt <= expo_cnt + EXPO_W'(1);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      exposure_active_output_o <= 1'b0;
    end else if (state == ST_IDLE) begin
      exposure_active_output_o <= trig_rise;
    end else if (expo_done) begin
      exposure_active_output_o <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      frame_start_o <= 1'b0;
    end else begin
      frame_start_o <= (state == ST_EXPOSE) && expo_done;
    end
  end

  // Each period is checked from its rising edge, where the divider has just
  // taken the period it keeps, so a binning change in a gap cannot trip it.
  sequence s_period_full;
    pclk_o[*2] ##1 (!pclk_o)[*3] ##1 pclk_o;
  endsequence

  sequence s_period_bin;
    pclk_o[*5] ##1 (!pclk_o)[*5] ##1 pclk_o;
  endsequence

  a_pclk_full_rate: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    $rose(pclk_o) && div_cur == pixel_link_pkg::DIV_FULL |-> s_period_full)
    else $error("pixel clock period is not 40 MHz");

  a_pclk_bin_rate: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    $rose(pclk_o) && div_cur == pixel_link_pkg::DIV_BIN |-> s_period_bin)
    else $error("pixel clock period is not 20 MHz while binning");

  a_data_on_fall: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    $changed(port_a_o) || $changed(port_b_o) || $changed(port_c_o) || $changed(lval_o)
    || $changed(fval_o)
    |-> $fell(pclk_o))
    else $error("serializer data changed away from a falling pixel clock");

  a_lval_in_frame: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    lval_o |-> fval_o)
    else $error("line qualifier high outside a frame");

  a_ten_bit_map: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    $fell(pclk_o) && !mode8 && $past(pix_fval_i && pix_lval_i)
    |-> port_a_o == $past(pix_odd_i[7:0]) && port_b_o[1:0] == $past(pix_odd_i[9:8])
        && port_b_o[5:4] == $past(pix_even_i[9:8]) && port_c_o == $past(pix_even_i[7:0]))
    else $error("dual 10-bit layout wrong");

  a_eight_bit_map: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    $fell(pclk_o) && mode8 && $past(pix_fval_i && pix_lval_i)
    |-> port_a_o == $past(pix_odd_i[9:2]) && port_b_o == $past(pix_even_i[9:2]))
    else $error("dual 8-bit layout wrong");

  a_unused_low: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    $fell(pclk_o) |-> (mode8 ? port_c_o == '0
                              : (port_b_o[3:2] == 2'h0 && port_b_o[7:6] == 2'h0)))
    else $error("unused serializer input not low");

  a_mode_in_gap: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    $changed(mode8) || $changed(bin_q) |-> !$past(fval_o))
    else $error("format changed inside a frame");

  a_expo_start: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    state == ST_IDLE && trig_rise |=> exposure_active_output_o && state == ST_EXPOSE)
    else $error("exposure did not start on a trigger edge");

  a_frame_per_expo: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    $fell(exposure_active_output_o) |-> frame_start_o ##1 !frame_start_o)
    else $error("frame start does not follow exposure end");

  a_take_on_fall: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    pix_take_o == $fell(pclk_o))
    else $error("take pulse does not mark the pixel clock fall");

  a_qual_follow: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    $fell(pclk_o) |-> fval_o == $past(pix_fval_i) && lval_o == $past(pix_fval_i && pix_lval_i))
    else $error("qualifiers do not follow the source frame and line");

  a_gap_data_zero: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    !lval_o |-> port_a_o == '0 && port_b_o == '0 && port_c_o == '0)
    else $error("pixel data not cleared outside a valid line");

  a_expo_on_edge: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    $rose(exposure_active_output_o) |-> $past(trig_s2) && !$past(trig_s3))
    else $error("exposure started without a trigger edge");

  a_level_expo_end: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    exposure_active_output_o && expo_mode == pixel_link_pkg::EXPO_LEVEL && trig_fall
    |=> !exposure_active_output_o)
    else $error("level exposure did not end on the trigger fall");
endmodule : camera_video_link_output
`default_nettype wire

// file: rtl/pixel_link_pkg.sv
`default_nettype none
package pixel_link_pkg;
  // System clock and pixel clock rates, in kHz.
  localparam int SYS_CLK_KHZ = 200000;
  localparam int PCLK_FULL_KHZ = 40000;
  localparam int PCLK_BIN_KHZ = 20000;
  localparam int DIV_W = 8;
  // System clock cycles per pixel clock period.
  localparam logic [DIV_W-1:0] DIV_FULL = DIV_W'(SYS_CLK_KHZ / PCLK_FULL_KHZ);
  localparam logic [DIV_W-1:0] DIV_BIN = DIV_W'(SYS_CLK_KHZ / PCLK_BIN_KHZ);
  localparam logic [DIV_W-1:0] DIV_RESET = DIV_FULL;
  // Pixel and serializer port layout.
  localparam int PIX_W = 10;
  localparam int PORT_W = 8;
  localparam int DROP_LSBS = 2;
  localparam int B_ODD_MSB_POS = 0;
  localparam int B_EVEN_MSB_POS = 4;
  // Least high time of the frame trigger, kept by the frame grabber.
  localparam int TRIG_MIN_HIGH_NS = 4000;
  localparam int SYS_CLK_PERIOD_NS = 5;
  localparam int TRIG_MIN_HIGH_CYC =
    (TRIG_MIN_HIGH_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int EXPO_W = 24;
  typedef enum logic {EXPO_LEVEL, EXPO_PROG} expo_mode_e;
endpackage : pixel_link_pkg
`default_nettype wire

// file: rtl/pclk_divider.sv
`default_nettype none
module pclk_divider #(
  parameter int DIV_W = 8
) (
  input wire logic sys_clk_i,          // System clock.
  input wire logic rstn_i,             // Asynchronous reset, active low.
  input wire logic [DIV_W-1:0] div_i,  // Wanted period in system cycles.
  output logic pclk_o,                 // Divided pixel clock.
  output logic fall_o,                 // High in the cycle whose edge drops pclk_o.
  output logic [DIV_W-1:0] div_cur_o   // Period now in use.
);
  logic [DIV_W-1:0] cnt;
  logic [DIV_W-1:0] next_cnt;
  logic [DIV_W-1:0] half;
  logic wrap;

  // A new period is taken only at a wrap, so no clock phase is ever cut short.
  assign wrap = (cnt >= div_cur_o - DIV_W'(1));
  assign next_cnt = wrap ? '0 : cnt + DIV_W'(1);
  assign half = div_cur_o >> 1;
  assign fall_o = pclk_o && !wrap && (next_cnt >= half);

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_cur_o <= DIV_W'(pixel_link_pkg::DIV_RESET);
    end else if (wrap) begin
      div_cur_o <= div_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pclk_o <= 1'b1;
    end else begin
      pclk_o <= wrap ? 1'b1 : (next_cnt < half);
    end
  end
endmodule : pclk_divider
`default_nettype wire

// file: tb/frame_grabber_model.sv
`default_nettype none
module frame_grabber_model (
  input wire logic pclk_i,          // Pixel clock from the camera.
  input wire logic [7:0] port_a_i,  // Serializer port A.
  input wire logic [7:0] port_b_i,  // Serializer port B.
  input wire logic [7:0] port_c_i,  // Serializer port C.
  input wire logic fval_i,          // Frame qualifier.
  input wire logic lval_i,          // Line qualifier.
  output logic trigger_o            // Frame trigger to the camera.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic gclk;
  int n_words;
  logic [23:0] last_word;
  // The grabber has its own clock, unrelated to the camera's.
  initial begin
    gclk = 1'b0;
    forever #32 gclk = ~gclk;
  end
  initial begin
    trigger_o = 1'b0;
    n_words = 0;
  end
  // Words outside an active line are thrown away.
  always @(posedge pclk_i) begin
    if (fval_i === 1'b1 && lval_i === 1'b1) begin
      n_words++;
      last_word = {port_a_i, port_b_i, port_c_i};
    end
  end
  // The trigger is moved only on the grabber's clock; each frame needs a new edge.
  task set_trig(input logic lvl);
    @(posedge gclk);
    trigger_o = lvl;
  endtask : set_trig
endmodule : frame_grabber_model
`default_nettype wire

// file: tb/camera_video_link_output_tb_top.sv
`default_nettype none
module camera_video_link_output_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, trig, c8, cbin, cprog, fv, lv;
  logic [23:0] elen;
  logic [9:0] po, pe;
  logic take, lval, fval, pclk, expo, fst;
  logic [7:0] pa, pb, pc;
  int mismatches, n_tests;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  camera_video_link_output camera_video_link_output_i (.sys_clk_i(clk), .rstn_i(rstn),
    .frame_trigger_input_i(trig), .cfg_8bit_i(c8), .cfg_bin_i(cbin), .cfg_prog_expo_i(cprog),
    .cfg_expo_len_i(elen), .pix_odd_i(po), .pix_even_i(pe), .pix_fval_i(fv), .pix_lval_i(lv),
    .pix_take_o(take), .port_a_o(pa), .port_b_o(pb), .port_c_o(pc), .lval_o(lval),
    .fval_o(fval), .pclk_o(pclk), .exposure_active_output_o(expo), .frame_start_o(fst));
  frame_grabber_model frame_grabber_model_i (.pclk_i(pclk), .port_a_i(pa), .port_b_i(pb),
    .port_c_i(pc), .fval_i(fval), .lval_i(lval), .trigger_o(trig));
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task close_out;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  task wait_expo(input logic lvl, output int k);
    k = 0;
    while (expo !== lvl && k < 2000) begin
      @(negedge clk);
      k++;
    end
  endtask : wait_expo
  task t_pclk(input logic bin);
    int k;
    cbin = bin;
    repeat (40) @(negedge clk);
    while (pclk !== 1'b0) @(negedge clk);
    while (pclk !== 1'b1) @(negedge clk);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (pclk !== 1'b0 || k < 2);
    while (pclk !== 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
    end
    chk("pclk period", bin ? 32'h0000000A : 32'h00000005, k);
    $display("test pclk bin=%0d done", bin);
  endtask : t_pclk
  task send_pair(input logic m8, input logic [9:0] o, input logic [9:0] e);
    int k;
    po = o;
    pe = e;
    fv = 1'b1;
    lv = 1'b1;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (take !== 1'b1 && k < 40);
    chk("take", 32'h00000001, take);
    chk("qualifiers", 32'h00000003, {fval, lval});
    chk("port a", m8 ? o[9:2] : o[7:0], pa);
    chk("port b", m8 ? e[9:2] : {2'h0, e[9:8], 2'h0, o[9:8]}, pb);
    chk("port c", m8 ? 8'h00 : e[7:0], pc);
  endtask : send_pair
  task t_line(input logic m8);
    int n0;
    c8 = m8;
    fv = 1'b0;
    lv = 1'b0;
    repeat (30) @(negedge clk);
    n0 = frame_grabber_model_i.n_words;
    send_pair(m8, 10'h3FF, 10'h000);
    c8 = ~m8;
    send_pair(m8, 10'h2AA, 10'h155);
    send_pair(m8, 10'h001, 10'h200);
    lv = 1'b0;
    repeat (12) @(negedge clk);
    chk("gap qualifiers", 32'h00000002, {fval, lval});
    chk("gap data", 32'h00000000, {pa, pb, pc});
    fv = 1'b0;
    repeat (12) @(negedge clk);
    chk("idle fval", 32'h00000000, fval);
    chk("words taken", 32'h00000003, frame_grabber_model_i.n_words - n0);
    chk("last word", m8 ? 32'h00008000 : 32'h00012000,
        frame_grabber_model_i.last_word);
    $display("test line 8bit=%0d done", m8);
  endtask : t_line
  task t_expo_level;
    int k;
    cprog = 1'b0;
    frame_grabber_model_i.set_trig(1'b1);
    wait_expo(1'b1, k);
    chk("expo start", 32'h00000001, k < 8);
    repeat (840) @(negedge clk);
    frame_grabber_model_i.set_trig(1'b0);
    wait_expo(1'b0, k);
    chk("expo end", 32'h00000001, k < 20);
    chk("frame start", 32'h00000001, fst);
    k = 0;
    repeat (200) begin
      @(negedge clk);
      k += (expo !== 1'b0);
    end
    chk("steady low", 32'h00000000, k);
    $display("test level exposure done");
  endtask : t_expo_level
  task t_expo_prog;
    int k;
    cprog = 1'b1;
    elen = 24'h000028;
    frame_grabber_model_i.set_trig(1'b1);
    wait_expo(1'b1, k);
    wait_expo(1'b0, k);
    chk("prog length", 32'h00000028, k);
    chk("frame start", 32'h00000001, fst);
    k = 0;
    repeat (800) begin
      @(negedge clk);
      k += (expo !== 1'b0);
    end
    chk("steady high", 32'h00000000, k);
    frame_grabber_model_i.set_trig(1'b0);
    $display("test programmable exposure done");
  endtask : t_expo_prog
  initial begin
    #100000;
    mismatches++;
    close_out();
  end
  initial begin
    mismatches = 0;
    n_tests = 0;
    rstn = 1'b0;
    {c8, cbin, cprog, fv, lv} = 5'h00;
    elen = 24'h000001;
    po = 10'h000;
    pe = 10'h000;
    repeat (6) @(negedge clk);
    chk("reset outputs", 32'h00000004, {pa, pb, pc, lval, fval, pclk, expo, fst});
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    t_pclk(1'b0);
    t_pclk(1'b1);
    t_line(1'b0);
    t_pclk(1'b0);
    t_line(1'b1);
    t_expo_level();
    t_expo_prog();
    close_out();
  end
endmodule : camera_video_link_output_tb_top
`default_nettype wire
